// ---- logic/asrp_map.svh ----
/*
 Named constants of the serial readout port: result layout, conversion timing and link counter sizes.
 Assumes a 50 MHz system clock; included by bare name wherever a number is needed.
*/
`ifndef ASRP_MAP_SVH
`define ASRP_MAP_SVH

`define ASRP_RESULT_BITS 16
`define ASRP_TOP_BIT 15
`define ASRP_CLK_PERIOD_NS 20
`define ASRP_CONV_TIME_NS 1500
`define ASRP_CONV_CYCLES (`ASRP_CONV_TIME_NS / `ASRP_CLK_PERIOD_NS)
`define ASRP_CYCLE_TIME_NS 2000
`define ASRP_FIFO_DEPTH 8
`define ASRP_LINK_CNT_W 8

`endif

// ---- logic/asrp_pkg.sv ----
/*
 Types shared by the serial readout port modules.
 Assumes asrp_map.svh supplies the numbers.
*/
package asrp_pkg;
    typedef enum logic {
        ASRP_MODE_SELECT,
        ASRP_MODE_DAISY
    } asrp_mode_t;

    typedef enum logic {
        ASRP_IDLE,
        ASRP_CONVERT
    } asrp_state_t;
endpackage : asrp_pkg

// ---- logic/asrp_fifo.sv ----
/*
 Result FIFO between the converter sample source and the readout port.
 Assumes both sides run on the system clock and reset.
*/
`timescale 1ns/1ps
module asrp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Filling side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Draining side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] fill_reg;

    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    wire [AW-1:0] wrPtrInc = (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
    wire [AW-1:0] rdPtrInc = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;

    assign inReady = (fill_reg != (AW + 1)'(DEPTH));
    assign outValid = (fill_reg != '0);
    assign outData = store[rdPtr_reg];

    always_ff @(posedge clock) begin
        if (push) begin
            store[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            fill_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtrInc;
            end
            if (pop) begin
                rdPtr_reg <= rdPtrInc;
            end
            fill_reg <= fill_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : asrp_fifo

// ---- logic/asrp_link.sv ----
/*
 Logic on the host's shift clock: counts shift edges and captures the chain input.
 Assumes the shift clock stands still outside frames; mode is a level steady during shifting.
*/
`timescale 1ns/1ps
`include "asrp_map.svh"
module asrp_link #(
    parameter int CW = `ASRP_LINK_CNT_W
) (
    // Link clock and reset
    input wire logic shiftClk,
    input wire logic reset_n,
    // Pins as seen at the falling edge
    input wire logic conversionStartStrobe,
    input wire logic chainDataIn,
    // Mode from the system side, steady through a frame
    input wire asrp_pkg::asrp_mode_t mode,
    // Edge count and delayed chain bit
    output logic [CW-1:0] edgeCount,
    output logic [CW-1:0] edgeGray,
    output logic chainDelayed
);
    import asrp_pkg::*;

    logic [CW-1:0] count_reg;
    logic [CW-1:0] gray_reg;
    logic [`ASRP_TOP_BIT:0] hist_reg;

    wire selected = (mode == ASRP_MODE_DAISY) || !conversionStartStrobe || !chainDataIn;
    wire [CW-1:0] countNext = count_reg + 1'b1;

    assign edgeCount = count_reg;
    assign edgeGray = gray_reg;
    assign chainDelayed = hist_reg[`ASRP_TOP_BIT];

    // Everything here moves on the falling edge only
    always_ff @(negedge shiftClk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
            gray_reg <= '0;
        end else if (selected) begin
            count_reg <= countNext;
            gray_reg <= countNext ^ (countNext >> 1);
        end
    end

    // Upstream bits sampled at each falling edge
    always_ff @(negedge shiftClk or negedge reset_n) begin
        if (!reset_n) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= {hist_reg[`ASRP_TOP_BIT-1:0], chainDataIn};
        end
    end

    property p_deselect_hold;
        @(negedge shiftClk) disable iff (!reset_n)
        !selected |=> count_reg == $past(count_reg);
    endproperty
    a_deselect_hold: assert property (p_deselect_hold) else $error("shift edge counted while deselected");

    property p_chain_sample;
        @(negedge shiftClk) disable iff (!reset_n)
        1'b1 |=> hist_reg[0] == $past(chainDataIn);
    endproperty
    a_chain_sample: assert property (p_chain_sample) else $error("chain input not sampled on falling edge");
endmodule : asrp_link

// ---- logic/asrp_port.sv ----
/*
 Serial result readout and conversion-start port of a single-channel converter.
 Assumes converter results arrive as a stream on the system clock; pins come from the host.
*/
// Behaviour
// - Start rising edge begins conversion, latches mode
// - Chain input low at start: daisy mode
// - Daisy mode passes upstream bits after ours
// - Chain input high at start: select mode
// - Select mode enables output when either low
// - Either low at completion enables busy indicator
// - Output data changes on shift falling edges
// - Shift clock ignored while deselected
// - Start falling shows top bit before shifting
// - Select mode releases output on high or end
// - Daisy busy: chain high drives output high
// - Chain input sampled on shift falling edges
`timescale 1ns/1ps
`include "asrp_map.svh"
module asrp_port #(
    parameter int BITS = `ASRP_RESULT_BITS,
    parameter int DEPTH = `ASRP_FIFO_DEPTH,
    parameter int CW = `ASRP_LINK_CNT_W
) (
    // System clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Host pins
    input wire logic shiftClk,
    input wire logic conversionStartStrobe,
    input wire logic chainDataIn,
    output logic resultDataOut,
    output logic resultDataOutEn,
    // Converter result stream
    input wire logic [BITS-1:0] sampleData,
    input wire logic sampleValid,
    output logic sampleReady,
    // Status
    output asrp_pkg::asrp_mode_t modeOut,
    output logic converting,
    output logic busyIndicatorOn,
    output logic resultMissed
);
    import asrp_pkg::*;

    localparam logic [7:0] CONV_LAST = 8'(`ASRP_CONV_CYCLES - 1);
    localparam int CONV_END = `ASRP_CONV_CYCLES + 1;

    function automatic logic [CW-1:0] grayToBin(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b = g;
        for (int i = CW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : grayToBin

    // Pin synchronisers
    logic startS1_reg;
    logic startS2_reg;
    logic startS3_reg;
    logic chainS1_reg;
    logic chainS2_reg;
    logic [CW-1:0] grayS1_reg;
    logic [CW-1:0] grayS2_reg;

    // Control state
    asrp_state_t state_reg;
    asrp_state_t state_next;
    asrp_mode_t mode_reg;
    logic [7:0] convCnt_reg;
    logic [BITS-1:0] word_reg;
    logic [CW-1:0] base_reg;
    logic busyEn_reg;
    logic haveResult_reg;
    logic missed_reg;
    logic outEn_reg;

    // Link side
    logic [CW-1:0] edgeCount;
    logic [CW-1:0] edgeGray;
    logic chainDelayed;

    // Result FIFO
    logic [BITS-1:0] fifoData;
    logic fifoValid;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            startS1_reg <= 1'b1;
            startS2_reg <= 1'b1;
            startS3_reg <= 1'b1;
            chainS1_reg <= 1'b1;
            chainS2_reg <= 1'b1;
            grayS1_reg <= '0;
            grayS2_reg <= '0;
        end else begin
            startS1_reg <= conversionStartStrobe;
            startS2_reg <= startS1_reg;
            startS3_reg <= startS2_reg;
            chainS1_reg <= chainDataIn;
            chainS2_reg <= chainS1_reg;
            grayS1_reg <= edgeGray;
            grayS2_reg <= grayS1_reg;
        end
    end

    // Decoding
    wire startRise = startS2_reg && !startS3_reg;
    wire convDone = (state_reg == ASRP_CONVERT) && (convCnt_reg == CONV_LAST);
    wire selectedNow = !startS2_reg || !chainS2_reg;
    wire [CW-1:0] syncIdx = grayToBin(grayS2_reg) - base_reg;
    wire [CW-1:0] linkIdx = edgeCount - base_reg;
    wire inWord = linkIdx < CW'(BITS);
    wire syncInWord = syncIdx < CW'(BITS);
    wire [3:0] bitSel = 4'(`ASRP_TOP_BIT) - linkIdx[3:0];
    wire busyHigh = (mode_reg == ASRP_MODE_DAISY) && busyEn_reg && chainS2_reg && (syncIdx == '0);
    wire asrp_mode_t modeAtStart = chainS2_reg ? ASRP_MODE_SELECT : ASRP_MODE_DAISY;
    wire selectEnable = selectedNow && syncInWord;
    wire daisyEnable = haveResult_reg || busyHigh;
    wire outEnNext = (mode_reg == ASRP_MODE_SELECT) ? selectEnable : daisyEnable;

    // Starts that arrive mid-conversion are ignored; the host spaces them
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ASRP_IDLE: begin
                if (startRise) begin
                    state_next = ASRP_CONVERT;
                end
            end
            ASRP_CONVERT: begin
                if (convDone) begin
                    state_next = ASRP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ASRP_IDLE;
            convCnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            convCnt_reg <= (state_reg == ASRP_CONVERT) ? convCnt_reg + 8'h01 : 8'h00;
        end
    end

    // Mode caught at the start edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= ASRP_MODE_SELECT;
        end else if (startRise && state_reg == ASRP_IDLE) begin
            mode_reg <= modeAtStart;
        end
    end

    // Result capture at completion; an empty FIFO keeps the old word and flags it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            word_reg <= '0;
            base_reg <= '0;
            busyEn_reg <= 1'b0;
            haveResult_reg <= 1'b0;
            missed_reg <= 1'b0;
        end else if (convDone) begin
            if (fifoValid) begin
                word_reg <= fifoData;
            end
            base_reg <= grayToBin(grayS2_reg);
            busyEn_reg <= selectedNow;
            haveResult_reg <= 1'b1;
            missed_reg <= !fifoValid;
        end
    end

    // Enable follows pins after the synchroniser, a few cycles late
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            outEn_reg <= 1'b0;
        end else begin
            outEn_reg <= outEnNext;
        end
    end

    // Data is a select of steady words by the link edge count; only the busy level and the converting zero follow the system clock
    always_comb begin
        if (state_reg == ASRP_CONVERT) begin
            resultDataOut = 1'b0;
        end else if (busyHigh) begin
            resultDataOut = 1'b1;
        end else if (inWord) begin
            resultDataOut = word_reg[bitSel];
        end else begin
            resultDataOut = chainDelayed;
        end
    end

    assign resultDataOutEn = outEn_reg;
    assign modeOut = mode_reg;
    assign converting = (state_reg == ASRP_CONVERT);
    assign busyIndicatorOn = busyEn_reg;
    assign resultMissed = missed_reg;

    asrp_link #(
        .CW(CW)
    ) i_asrp_link (
        .shiftClk(shiftClk),
        .reset_n(reset_n),
        .conversionStartStrobe(conversionStartStrobe),
        .chainDataIn(chainDataIn),
        .mode(mode_reg),
        .edgeCount(edgeCount),
        .edgeGray(edgeGray),
        .chainDelayed(chainDelayed)
    );

    asrp_fifo #(
        .WIDTH(BITS),
        .DEPTH(DEPTH)
    ) i_asrp_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .inData(sampleData),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(convDone)
    );

    sequence s_start;
        startRise && state_reg == ASRP_IDLE;
    endsequence

    property p_start_converts;
        @(posedge clock) disable iff (!reset_n)
        s_start |=> state_reg == ASRP_CONVERT && convCnt_reg == 8'h00;
    endproperty
    a_start_converts: assert property (p_start_converts) else $error("start edge did not begin conversion");

    property p_conv_length;
        @(posedge clock) disable iff (!reset_n)
        s_start |-> ##CONV_END state_reg == ASRP_IDLE ##0 $past(convDone);
    endproperty
    a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

    property p_daisy_mode;
        @(posedge clock) disable iff (!reset_n)
        s_start ##0 !chainS2_reg |=> mode_reg == ASRP_MODE_DAISY;
    endproperty
    a_daisy_mode: assert property (p_daisy_mode) else $error("daisy mode not latched");

    property p_select_mode;
        @(posedge clock) disable iff (!reset_n)
        s_start ##0 chainS2_reg |=> mode_reg == ASRP_MODE_SELECT;
    endproperty
    a_select_mode: assert property (p_select_mode) else $error("select mode not latched");

    property p_select_enable;
        @(posedge clock) disable iff (!reset_n)
        mode_reg == ASRP_MODE_SELECT && selectedNow && syncInWord ##1 mode_reg == ASRP_MODE_SELECT
            |-> resultDataOutEn;
    endproperty
    a_select_enable: assert property (p_select_enable) else $error("output not enabled when selected");

    property p_select_release;
        @(posedge clock) disable iff (!reset_n)
        mode_reg == ASRP_MODE_SELECT && (!selectedNow || !syncInWord) ##1 mode_reg == ASRP_MODE_SELECT
            |-> !resultDataOutEn;
    endproperty
    a_select_release: assert property (p_select_release) else $error("output not released");

    property p_busy_enable;
        @(posedge clock) disable iff (!reset_n)
        convDone |=> busyIndicatorOn == $past(selectedNow) && !converting;
    endproperty
    a_busy_enable: assert property (p_busy_enable) else $error("busy indicator choice wrong");

    property p_top_bit_first;
        @(posedge clock) disable iff (!reset_n)
        state_reg == ASRP_IDLE && !busyHigh && linkIdx == '0 |-> resultDataOut == word_reg[`ASRP_TOP_BIT];
    endproperty
    a_top_bit_first: assert property (p_top_bit_first) else $error("top bit not presented first");

    property p_busy_high;
        @(posedge clock) disable iff (!reset_n)
        busyHigh && state_reg == ASRP_IDLE |-> resultDataOut ##1 resultDataOutEn;
    endproperty
    a_busy_high: assert property (p_busy_high) else $error("busy high not driven");

    property p_missed_flag;
        @(posedge clock) disable iff (!reset_n)
        convDone |=> resultMissed == !$past(fifoValid);
    endproperty
    a_missed_flag: assert property (p_missed_flag) else $error("missed result flag wrong");

    property p_daisy_enable;
        @(posedge clock) disable iff (!reset_n)
        mode_reg == ASRP_MODE_DAISY && haveResult_reg |=> resultDataOutEn;
    endproperty
    a_daisy_enable: assert property (p_daisy_enable) else $error("daisy output not enabled");
endmodule : asrp_port

// ---- dv/asrp_host.sv ----
/*
 Host model: drives the start pin, the chain pin and the shift clock, and plays an upstream converter.
 Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
module asrp_host (
    // System clock
    input wire logic clock,
    // Pins
    input wire logic resultDataOut,
    output logic shiftClk,
    output logic conversionStartStrobe,
    output logic chainDataIn
);
    initial begin
        shiftClk = 1'b0; // Still between frames
        conversionStartStrobe = 1'b0;
        chainDataIn = 1'b1;
    end

    task automatic setPins(input logic s, input logic c);
        @(posedge clock);
        conversionStartStrobe <= s;
        chainDataIn <= c;
    endtask : setPins

    // Chain level held over the rise picks the mode
    task automatic startConv(input logic c);
        setPins(1'b0, c);
        repeat (100) @(posedge clock);
        conversionStartStrobe <= 1'b1;
    endtask : startConv

    // Reads in the high half, before each fall; upstream changes only after falls
    task automatic shiftFrame(input int n, input logic daisy, input logic [15:0] up, output logic [31:0] got);
        got = 32'h00000000;
        #7;
        // A full period ahead, so the synchronised busy level has cleared before the first read
        if (daisy) begin
            chainDataIn = up[15];
            #64;
        end
        for (int k = 1; k <= n; k++) begin
            shiftClk = 1'b1;
            #16 got = {got[30:0], resultDataOut};
            #16 shiftClk = 1'b0;
            // Released upstream line shows the inverse, never a stale level
            #8 if (daisy) chainDataIn = (k < 16) ? up[15-k] : ~chainDataIn;
            #24;
        end
    endtask : shiftFrame
endmodule : asrp_host

// ---- dv/asrp_port_bench.sv ----
/*
 Self-checking bench of the serial readout port.
 Assumes the host model owns the pins; the bench feeds the result stream.
*/
`timescale 1ns/1ps
module asrp_port_bench;
    import asrp_pkg::*;
    localparam logic [15:0] WORDS [8] = '{16'h8001, 16'h7FFE, 16'h435A, 16'h0F0F,
                                          16'h1234, 16'hFEDC, 16'h5555, 16'hAAAA};
    logic clock, reset_n, shiftClk, conversionStartStrobe, chainDataIn, resultDataOut, resultDataOutEn;
    logic [15:0] sampleData;
    logic sampleValid, sampleReady, converting, busyIndicatorOn, resultMissed;
    asrp_mode_t modeOut;
    int errorCnt = 0;
    int comparisons = 0;
    logic [31:0] got;

    asrp_port i_asrp_port (.clock(clock), .reset_n(reset_n), .shiftClk(shiftClk),
        .conversionStartStrobe(conversionStartStrobe), .chainDataIn(chainDataIn),
        .resultDataOut(resultDataOut), .resultDataOutEn(resultDataOutEn), .sampleData(sampleData),
        .sampleValid(sampleValid), .sampleReady(sampleReady), .modeOut(modeOut),
        .converting(converting), .busyIndicatorOn(busyIndicatorOn), .resultMissed(resultMissed));
    asrp_host i_asrp_host (.clock(clock), .resultDataOut(resultDataOut), .shiftClk(shiftClk),
        .conversionStartStrobe(conversionStartStrobe), .chainDataIn(chainDataIn));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            errorCnt++;
        end
    endtask : chk

    task automatic printVerdict;
        $display("errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : printVerdict

    task automatic clocks(input int n);
        repeat (n) @(negedge clock);
    endtask : clocks

    // Bounded wait; exp of zero skips the length compare
    task automatic waitConv(input int exp);
        int n;
        n = 0;
        while (converting !== 1'b1 && n < 10) begin @(negedge clock); n++; end
        n = 0;
        while (converting === 1'b1 && n < 200) begin @(negedge clock); n++; end
        if (exp != 0) chk("conversion cycles", exp, n);
        if (n == 0 || n >= 200) begin
            errorCnt++;
            printVerdict();
        end
    endtask : waitConv

    // Fill until refused; conversions drain it later
    task automatic fillFifo;
        for (int i = 0; i < 8; i++) begin
            @(negedge clock);
            chk("ready while filling", 32'h00000001, sampleReady);
            @(posedge clock);
            sampleData <= WORDS[i];
            sampleValid <= 1'b1;
        end
        @(posedge clock);
        sampleValid <= 1'b0;
        @(negedge clock);
        chk("ready when full", 32'h00000000, sampleReady);
    endtask : fillFifo

    task automatic selectFrame;
        i_asrp_host.startConv(1'b1);
        waitConv(75);
        chk("mode", ASRP_MODE_SELECT, modeOut);
        chk("busy armed", 32'h00000000, busyIndicatorOn);
        chk("result missed", 32'h00000000, resultMissed);
        chk("enable deselected", 32'h00000000, resultDataOutEn);
        i_asrp_host.shiftFrame(3, 1'b0, 16'h0000, got);
        i_asrp_host.setPins(1'b0, 1'b1);
        clocks(5);
        chk("enable", 32'h00000001, resultDataOutEn);
        chk("top bit", WORDS[0][15], resultDataOut);
        i_asrp_host.shiftFrame(16, 1'b0, 16'h0000, got);
        chk("select word", {16'h0000, WORDS[0]}, got);
        clocks(5);
        chk("enable after last edge", 32'h00000000, resultDataOutEn);
    endtask : selectFrame

    // Chain pin selects and arms busy; frame cut short by the chain pin
    task automatic selectBusy;
        i_asrp_host.startConv(1'b1);
        clocks(10);
        i_asrp_host.setPins(1'b1, 1'b0);
        clocks(5);
        chk("data while converting", 32'h00000000, resultDataOut);
        waitConv(0);
        clocks(2);
        chk("busy armed", 32'h00000001, busyIndicatorOn);
        chk("enable by chain", 32'h00000001, resultDataOutEn);
        i_asrp_host.shiftFrame(8, 1'b0, 16'h0000, got);
        chk("first byte", {24'h000000, WORDS[1][15:8]}, got);
        i_asrp_host.setPins(1'b1, 1'b1);
        clocks(5);
        chk("enable after chain high", 32'h00000000, resultDataOutEn);
    endtask : selectBusy

    task automatic daisyFrame;
        i_asrp_host.startConv(1'b0);
        waitConv(75);
        chk("mode", ASRP_MODE_DAISY, modeOut);
        chk("busy armed", 32'h00000001, busyIndicatorOn);
        i_asrp_host.setPins(1'b1, 1'b1);
        clocks(5);
        chk("busy level", 32'h00000001, resultDataOut);
        chk("busy enable", 32'h00000001, resultDataOutEn);
        i_asrp_host.shiftFrame(32, 1'b1, 16'h6C39, got);
        chk("chained words", {WORDS[2], 16'h6C39}, got);
    endtask : daisyFrame

    initial begin
        reset_n = 1'b0;
        sampleData = 16'h0000;
        sampleValid = 1'b0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        fillFifo();
        selectFrame();
        selectBusy();
        daisyFrame();
        chk("ready after pops", 32'h00000001, sampleReady);
        printVerdict();
    end
endmodule : asrp_port_bench
